// file: splk_pkg.sv
package splk_pkg;
    // ****************************************
    // protection mode encodings
    // ****************************************
    localparam logic [1:0] SPLK_MODE_DEFAULT = 2'h3;
    localparam logic [1:0] SPLK_MODE_PERSIST = 2'h2;
    localparam logic [1:0] SPLK_MODE_PASSWD = 2'h1;
    localparam logic [1:0] SPLK_MODE_ILLEGAL = 2'h0;
    localparam int SPLK_PW_W = 64;
    localparam logic [63:0] SPLK_PW_RESET = 64'hffffffffffffffff;
    // ****************************************
    // register offsets (plain port)
    // ****************************************
    localparam int SPLK_AW = 4;
    localparam logic [3:0] SPLK_A_CMD = 4'h0;
    localparam logic [3:0] SPLK_A_SECT = 4'h1;
    localparam logic [3:0] SPLK_A_STATUS = 4'h2;
    localparam logic [3:0] SPLK_A_MODE = 4'h3;
    localparam logic [3:0] SPLK_A_PWLO = 4'h4;
    localparam logic [3:0] SPLK_A_PWHI = 4'h5;
    localparam logic [3:0] SPLK_A_VLOCK = 4'h6;
    localparam logic [3:0] SPLK_A_PLOCK = 4'h7;
    localparam logic [3:0] SPLK_A_RDADDR = 4'h8;
    // ****************************************
    // command codes written to the command register
    // ****************************************
    localparam logic [3:0] SPLK_C_VSET = 4'h1;
    localparam logic [3:0] SPLK_C_VCLR = 4'h2;
    localparam logic [3:0] SPLK_C_PPROG = 4'h3;
    localparam logic [3:0] SPLK_C_PERASE = 4'h4;
    localparam logic [3:0] SPLK_C_GCLR = 4'h5;
    localparam logic [3:0] SPLK_C_UNLOCK = 4'h6;
    localparam logic [3:0] SPLK_C_PWPROG = 4'h7;
    localparam logic [3:0] SPLK_C_MODEPROG = 4'h8;
    localparam logic [3:0] SPLK_C_SWRST = 4'h9;
    localparam logic [3:0] SPLK_C_CLRERR = 4'ha;
    // ****************************************
    // status fields
    // ****************************************
    localparam int SPLK_S_WIP = 0;
    localparam int SPLK_S_PERR = 1;
    localparam int SPLK_S_GUARD = 2;
    // ****************************************
    // timing
    // ****************************************
    localparam int SPLK_CLK_MHZ = 125;
    localparam int SPLK_THROTTLE_US = 100;
    localparam int SPLK_THROTTLE_CYC = SPLK_THROTTLE_US * SPLK_CLK_MHZ;
    typedef enum logic [1:0] {
        SPLK_IDLE = 2'h1,
        SPLK_WAIT = 2'h2
    } splk_state_t;
endpackage

// file: splk_sector_lock.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - per-sector volatile lock, set or cleared freely
// - volatile lock counts only if persistent is one
// - guard zero blocks persistent changes, one allows
// - guard-clear command clears guard
// - persistent mode: reset sets guard, no resetting
// - software reset leaves guard unchanged
// - password mode: reset clears, unlock sets
// - unprotected only when both lock bits one
// - volatile writes allowed while guard zero
// - volatile lost on reset, persistent kept
// - full 64-bit compare, every value legal
// - password program only clears bits, no error
// - password starts as all ones
// - password mode ignores programming, reads return zero
// - mismatch sets error, busy for the throttle time, guard unchanged
// - failed unlock blocks all commands for 100 us
// - matching password skips the throttle delay
// - mode bits never erase back to one
// - read protection forces reads to boot sector
// - guard zero aborts persistent program and erase
// - mode decode 11 default, 10, 01, 00 illegal
// - block protect ORed with sector locks
module splk_sector_lock
    import splk_pkg::*;
#(
    parameter int NSECT = 32,
    parameter int THROTTLE = SPLK_THROTTLE_CYC,
    parameter int BOOT_SECT = 0
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [SPLK_AW-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic [NSECT-1:0] i_block_protect,
    input wire logic i_read_protect,
    output logic [NSECT-1:0] o_sector_protected,
    output logic o_write_in_progress,
    output logic o_guard
);
    initial begin
        if (NSECT < 1 || NSECT > 32 || THROTTLE < 1 ||
            BOOT_SECT >= NSECT) begin
            $error("splk_sector_lock: bad parameter");
        end
    end
    localparam int SW = (NSECT > 1) ? $clog2(NSECT) : 1;
    localparam logic [31:0] THR_LAST = 32'(THROTTLE - 1);
    // ****************************************
    // decode
    // ****************************************
    logic [3:0] cmd;
    logic cmd_go;
    assign cmd = i_wdata[3:0];
    assign cmd_go = i_wr && (i_addr == SPLK_A_CMD) && !o_write_in_progress;
    logic is_pw_mode;
    logic [1:0] mode_q;
    assign is_pw_mode = (mode_q == SPLK_MODE_PASSWD);
    logic [SW-1:0] sect_q;
    logic [31:0] pwlo_q;
    logic [31:0] pwhi_q;
    logic [SPLK_PW_W-1:0] pw_cand;
    assign pw_cand = {pwhi_q, pwlo_q};
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            sect_q <= '0;
            pwlo_q <= '0;
            pwhi_q <= '0;
        end else if (i_wr) begin
            if (i_addr == SPLK_A_SECT) begin
                sect_q <= i_wdata[SW-1:0];
            end
            if (i_addr == SPLK_A_PWLO) begin
                pwlo_q <= i_wdata;
            end
            if (i_addr == SPLK_A_PWHI) begin
                pwhi_q <= i_wdata;
            end
        end
    end
    // ****************************************
    // persistent storage (not cleared by reset)
    // ****************************************
    logic [NSECT-1:0] plock_q;
    logic [SPLK_PW_W-1:0] pw_q;
    // two-state so the first edge sees 0 and loads the factory image;
    // a four-state flag would stay unknown and never load it
    bit plock_init_q;
    logic guard_q;
    logic busy_q;
    logic perr_q;
    always_ff @(posedge i_mclk) begin
        if (!plock_init_q) begin
            plock_q <= '1;
            pw_q <= SPLK_PW_RESET;
            mode_q <= SPLK_MODE_DEFAULT;
        end else if (cmd_go) begin
            if (cmd == SPLK_C_PPROG && guard_q) begin
                plock_q[sect_q] <= 1'b0;
            end
            if (cmd == SPLK_C_PERASE && guard_q) begin
                plock_q <= '1;
            end
            if (cmd == SPLK_C_PWPROG && mode_q == SPLK_MODE_DEFAULT) begin
                pw_q <= pw_q & pw_cand;
            end
            // only one bit may go low, and only from default
            if (cmd == SPLK_C_MODEPROG && mode_q == SPLK_MODE_DEFAULT &&
                (i_wdata[5:4] == SPLK_MODE_PERSIST ||
                 i_wdata[5:4] == SPLK_MODE_PASSWD)) begin
                mode_q <= i_wdata[5:4];
            end
        end
    end
    // first-cycle init stands in for factory state of the array
    always_ff @(posedge i_mclk) begin
        plock_init_q <= 1'b1;
    end
    // ****************************************
    // volatile locks
    // ****************************************
    logic [NSECT-1:0] vlock_q;
    genvar v;
    generate
        for (v = 0; v < NSECT; v++) begin : g_vlock
            // one flop per sector; the guard is not consulted here
            always_ff @(posedge i_mclk or negedge i_nrst) begin
                if (!i_nrst) begin
                    vlock_q[v] <= 1'b1;
                end else if (cmd_go && sect_q == SW'(v)) begin
                    if (cmd == SPLK_C_VSET) begin
                        vlock_q[v] <= 1'b1;
                    end
                    if (cmd == SPLK_C_VCLR) begin
                        vlock_q[v] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
    // ****************************************
    // guard and unlock throttle
    // ****************************************
    splk_state_t state_q;
    logic [31:0] thr_q;
    logic gclr;
    logic unlock;
    logic match;
    logic mode_prog_ok;
    assign gclr = cmd_go && cmd == SPLK_C_GCLR;
    assign unlock = cmd_go && cmd == SPLK_C_UNLOCK && is_pw_mode;
    assign match = (pw_cand == pw_q);
    assign mode_prog_ok = (i_wdata[5:4] == SPLK_MODE_PERSIST ||
                           i_wdata[5:4] == SPLK_MODE_PASSWD) &&
                          mode_q == SPLK_MODE_DEFAULT;
    // guard resets to 1; password mode is cleared in the first cycle
    logic guard_fix_q;
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            guard_q <= 1'b1;
            guard_fix_q <= 1'b0;
        end else begin
            guard_fix_q <= 1'b1;
            if (!guard_fix_q && is_pw_mode) begin
                guard_q <= 1'b0;
            end else if (gclr) begin
                guard_q <= 1'b0;
            end else if (unlock && match) begin
                guard_q <= 1'b1;
            end
            // software reset command does not touch the guard
        end
    end
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= SPLK_IDLE;
            thr_q <= '0;
            busy_q <= 1'b0;
        end else begin
            case (state_q)
                SPLK_IDLE: begin
                    if (unlock && !match) begin
                        state_q <= SPLK_WAIT;
                        thr_q <= '0;
                        busy_q <= 1'b1;
                    end
                    // a match completes with no busy time
                end
                SPLK_WAIT: begin
                    if (thr_q == THR_LAST) begin
                        state_q <= SPLK_IDLE;
                        busy_q <= 1'b0;
                    end else begin
                        thr_q <= thr_q + 32'h1;
                    end
                end
                default: begin
                    state_q <= SPLK_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end
    // program error: hardware set wins over software clear
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            perr_q <= 1'b0;
        end else if (unlock && !match) begin
            perr_q <= 1'b1;
        end else if (cmd_go && cmd == SPLK_C_MODEPROG && !mode_prog_ok) begin
            perr_q <= 1'b1;
        end else if (cmd_go && (cmd == SPLK_C_CLRERR ||
                                cmd == SPLK_C_SWRST)) begin
            perr_q <= 1'b0;
        end
    end
    assign o_write_in_progress = busy_q;
    assign o_guard = guard_q;
    // ****************************************
    // protection outputs
    // ****************************************
    logic [NSECT-1:0] prot_d;
    logic [NSECT-1:0] prot_q;
    genvar g;
    generate
        for (g = 0; g < NSECT; g++) begin : g_sect
            assign prot_d[g] = i_block_protect[g] ||
                               !(plock_q[g] && vlock_q[g]);
        end
    endgenerate
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            prot_q <= '1;
        end else begin
            prot_q <= prot_d;
        end
    end
    assign o_sector_protected = prot_q;
    // ****************************************
    // read port
    // ****************************************
    logic [31:0] rd_d;
    logic [31:0] rdata_q;
    logic [31:0] vpad;
    logic [31:0] ppad;
    always_comb begin
        vpad = '0;
        ppad = '0;
        vpad[NSECT-1:0] = vlock_q;
        ppad[NSECT-1:0] = plock_q;
        rd_d = '0;
        case (i_addr)
            SPLK_A_SECT: rd_d[SW-1:0] = sect_q;
            SPLK_A_STATUS: begin
                rd_d[SPLK_S_WIP] = busy_q;
                rd_d[SPLK_S_PERR] = perr_q;
                rd_d[SPLK_S_GUARD] = guard_q;
            end
            SPLK_A_MODE: rd_d[1:0] = mode_q;
            // stored password hidden once password mode selected
            SPLK_A_PWLO: rd_d = is_pw_mode ? 32'h0 : pw_q[31:0];
            SPLK_A_PWHI: rd_d = is_pw_mode ? 32'h0 : pw_q[63:32];
            SPLK_A_VLOCK: rd_d = vpad;
            SPLK_A_PLOCK: rd_d = ppad;
            SPLK_A_RDADDR: rd_d = i_read_protect ? 32'(BOOT_SECT) : i_wdata;
            default: rd_d = '0;
        endcase
    end
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_q <= '0;
        end else if (i_rd) begin
            rdata_q <= rd_d;
        end else begin
            rdata_q <= '0;
        end
    end
    assign o_rdata = rdata_q;
endmodule
`default_nettype wire

// file: splk_host.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// host model: drives the register port only right after an edge
// ****
module splk_host
    import splk_pkg::*;
(
    input wire logic i_mclk,
    input wire logic [31:0] i_rdata,
    output logic [SPLK_AW-1:0] o_addr,
    output logic [31:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    initial begin
        o_addr = 4'h0;
        o_wdata = 32'h0;
        o_wr = 1'h0;
        o_rd = 1'h0;
    end
    // data is inverted once released so a stale value never looks valid
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'h1;
        @(posedge i_mclk);
        o_wr <= 1'h0;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge i_mclk);
        o_addr <= a;
        o_wdata <= d;
        o_rd <= 1'h1;
        @(posedge i_mclk);
        o_rd <= 1'h0;
        #1;
        q = i_rdata;
    endtask
    // callers set the persistent locks and password before guard clear
    // and mode select; no freeze path exists here to drive
    task automatic cmd(input logic [3:0] c, input logic [31:0] s);
        wr(SPLK_A_SECT, s);
        wr(SPLK_A_CMD, {28'h0, c});
    endtask
endmodule
`default_nettype wire

// file: splk_sector_lock_props.sv
`timescale 1ns/100ps
`default_nettype none
module splk_sector_lock_chk
    import splk_pkg::*;
#(
    parameter int NSECT = 32,
    parameter int THROTTLE = SPLK_THROTTLE_CYC,
    parameter int BOOT_SECT = 0
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [SPLK_AW-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [NSECT-1:0] i_block_protect,
    input wire logic i_read_protect,
    input wire logic [NSECT-1:0] o_sector_protected,
    input wire logic o_write_in_progress,
    input wire logic o_guard
);
    logic [15:0] busy_q;
    logic cmd_w;
    assign cmd_w = i_wr && i_addr == SPLK_A_CMD && !o_write_in_progress;
    // counter instead of a repetition: the throttle is too long to unroll
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            busy_q <= 16'h0;
        end else begin
            busy_q <= o_write_in_progress ? busy_q + 16'h1 : 16'h0;
        end
    end
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);
    chk_block_or:
    assert property (($past(i_block_protect, 2) & $past(i_block_protect)
        & ~o_sector_protected) == '0) else $error("block protect lost");
    chk_guard_source:
    assert property ($rose(o_guard) |->
        $past(cmd_w && i_wdata[3:0] == SPLK_C_UNLOCK))
        else $error("guard set without unlock");
    chk_guard_clear:
    assert property (cmd_w && i_wdata[3:0] == SPLK_C_GCLR |=> !o_guard)
        else $error("guard not cleared");
    chk_busy_source:
    assert property ($rose(o_write_in_progress) |->
        $past(cmd_w && i_wdata[3:0] == SPLK_C_UNLOCK))
        else $error("busy without unlock");
    chk_busy_length:
    assert property ($fell(o_write_in_progress) |-> busy_q == 16'(THROTTLE))
        else $error("throttle length wrong");
    chk_busy_max:
    assert property (busy_q <= 16'(THROTTLE)) else $error("busy too long");
    chk_busy_guard:
    assert property (o_write_in_progress |-> !o_guard)
        else $error("guard set while busy");
    chk_unlock_fast:
    assert property ($rose(o_guard) |-> !$past(o_write_in_progress))
        else $error("unlock went busy");
    chk_boot_read:
    assert property ($past(i_rd && i_addr == SPLK_A_RDADDR && i_read_protect)
        |-> o_rdata == 32'(BOOT_SECT)) else $error("read not forced");
    cover property ($rose(o_write_in_progress));
    cover property ($rose(o_guard));
    cover property ($fell(o_guard));
    cover property (|i_block_protect);
endmodule
bind splk_sector_lock splk_sector_lock_chk #(.NSECT(NSECT),
    .THROTTLE(THROTTLE), .BOOT_SECT(BOOT_SECT)) splk_sector_lock_chk_inst (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_block_protect(i_block_protect), .i_read_protect(i_read_protect),
    .o_sector_protected(o_sector_protected),
    .o_write_in_progress(o_write_in_progress), .o_guard(o_guard));
`default_nettype wire

// file: splk_sector_lock_tb.sv
`timescale 1ns/100ps
`default_nettype none
module splk_sector_lock_tb;
    import splk_pkg::*;
    logic i_mclk, i_nrst, i_wr, i_rd, i_read_protect, write_in_progress, guard;
    logic [3:0] i_addr;
    logic [31:0] i_wdata, o_rdata, q;
    logic [7:0] i_block_protect, prot;
    int n_fail, checked, cyc, w;
    splk_sector_lock #(.NSECT(8), .THROTTLE(20), .BOOT_SECT(3))
        splk_sector_lock_inst (.i_mclk(i_mclk), .i_nrst(i_nrst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_block_protect(i_block_protect),
        .i_read_protect(i_read_protect), .o_sector_protected(prot),
        .o_write_in_progress(write_in_progress), .o_guard(guard));
    splk_host splk_host_inst (.i_mclk(i_mclk), .i_rdata(o_rdata),
        .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
    initial begin
        i_mclk = 1'h0;
        forever #4 i_mclk = ~i_mclk;
    end
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        splk_host_inst.rd(a, 32'h7, q);
        chk($sformatf("reg %h", a), e, q);
    endtask
    task automatic hw_reset();
        @(posedge i_mclk);
        i_nrst <= 1'h0;
        repeat (4) @(posedge i_mclk);
        i_nrst <= 1'h1;
        @(posedge i_mclk);
    endtask
    // ****
    // default mode: persistent and volatile locks, guard, resets, block and read protect
    // ****
    task automatic t_persist();
        rdc(SPLK_A_STATUS, 32'h4);
        rdc(SPLK_A_PWLO, 32'hffffffff);
        rdc(SPLK_A_MODE, 32'h3);
        splk_host_inst.cmd(SPLK_C_VCLR, 32'h1);
        splk_host_inst.cmd(SPLK_C_PPROG, 32'h5);
        rdc(SPLK_A_VLOCK, 32'hfd);
        rdc(SPLK_A_PLOCK, 32'hdf);
        chk("prot", 32'h22, {24'h0, prot});
        splk_host_inst.cmd(SPLK_C_VSET, 32'h1);
        splk_host_inst.cmd(SPLK_C_VSET, 32'h5);
        chk("prot", 32'h20, {24'h0, prot});
        i_block_protect <= 8'h04;
        i_read_protect <= 1'h1;
        rdc(SPLK_A_RDADDR, 32'h3);
        i_read_protect <= 1'h0;
        rdc(SPLK_A_RDADDR, 32'h7);
        chk("prot", 32'h24, {24'h0, prot});
        i_block_protect <= 8'h00;
        splk_host_inst.cmd(SPLK_C_GCLR, 32'h0);
        rdc(SPLK_A_STATUS, 32'h0);
        splk_host_inst.cmd(SPLK_C_PPROG, 32'h6);
        splk_host_inst.cmd(SPLK_C_PERASE, 32'h0);
        rdc(SPLK_A_PLOCK, 32'hdf);
        splk_host_inst.cmd(SPLK_C_VCLR, 32'h2);
        rdc(SPLK_A_VLOCK, 32'hfb);
        splk_host_inst.cmd(SPLK_C_SWRST, 32'h0);
        rdc(SPLK_A_STATUS, 32'h0);
        hw_reset();
        rdc(SPLK_A_STATUS, 32'h4);
        rdc(SPLK_A_VLOCK, 32'hff);
        rdc(SPLK_A_PLOCK, 32'hdf);
        splk_host_inst.cmd(SPLK_C_PERASE, 32'h0);
        rdc(SPLK_A_PLOCK, 32'hff);
        splk_host_inst.wr(SPLK_A_CMD, 32'h08);
        rdc(SPLK_A_MODE, 32'h3);
        rdc(SPLK_A_STATUS, 32'h6);
        splk_host_inst.wr(SPLK_A_CMD, {28'h0, SPLK_C_CLRERR});
        rdc(SPLK_A_STATUS, 32'h4);
    endtask
    // ****
    // password mode: program, select, throttle, unlock
    // ****
    task automatic t_passwd();
        splk_host_inst.wr(SPLK_A_PWLO, 32'h89abcdef);
        splk_host_inst.wr(SPLK_A_PWHI, 32'h01234567);
        splk_host_inst.cmd(SPLK_C_PWPROG, 32'h0);
        splk_host_inst.wr(SPLK_A_PWLO, 32'hffffffff);
        splk_host_inst.wr(SPLK_A_PWHI, 32'hffff0000);
        splk_host_inst.cmd(SPLK_C_PWPROG, 32'h0);
        rdc(SPLK_A_PWLO, 32'h89abcdef);
        rdc(SPLK_A_PWHI, 32'h01230000);
        rdc(SPLK_A_STATUS, 32'h4);
        splk_host_inst.wr(SPLK_A_CMD, 32'h18);
        rdc(SPLK_A_MODE, 32'h1);
        splk_host_inst.wr(SPLK_A_CMD, 32'h28);
        rdc(SPLK_A_MODE, 32'h1);
        splk_host_inst.wr(SPLK_A_PWLO, 32'h0);
        splk_host_inst.cmd(SPLK_C_PWPROG, 32'h0);
        rdc(SPLK_A_PWLO, 32'h0);
        hw_reset();
        splk_host_inst.wr(SPLK_A_CMD, {28'h0, SPLK_C_CLRERR});
        rdc(SPLK_A_STATUS, 32'h0);
        splk_host_inst.wr(SPLK_A_PWLO, 32'h89abcdef);
        splk_host_inst.wr(SPLK_A_PWHI, 32'h81230000);
        splk_host_inst.wr(SPLK_A_CMD, {28'h0, SPLK_C_UNLOCK});
        rdc(SPLK_A_STATUS, 32'h3);
        splk_host_inst.wr(SPLK_A_PWHI, 32'h01230000);
        splk_host_inst.wr(SPLK_A_CMD, {28'h0, SPLK_C_UNLOCK});
        rdc(SPLK_A_STATUS, 32'h3);
        w = 0;
        while (write_in_progress === 1'h1 && w < 30) begin
            @(posedge i_mclk);
            w++;
        end
        chk("wip", 32'h0, {31'h0, write_in_progress});
        splk_host_inst.wr(SPLK_A_CMD, {28'h0, SPLK_C_UNLOCK});
        rdc(SPLK_A_STATUS, 32'h6);
    endtask
    task automatic final_report();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            final_report();
        end
    end
    initial begin
        i_nrst = 1'h0;
        i_block_protect = 8'h0;
        i_read_protect = 1'h0;
        repeat (4) @(posedge i_mclk);
        i_nrst <= 1'h1;
        @(posedge i_mclk);
        t_persist();
        t_passwd();
        final_report();
    end
endmodule
`default_nettype wire
